// ==== urhps_top.sv ====
// root hub port status and control registers behind an axi4-lite slave
`timescale 1ns/10ps
module urhps_top #(
  parameter int NUM_PORTS = 3,
  parameter int RESET_CYCLES = urhps_pkg::URHPS_RESET_CYCLES,
  parameter int RESUME_CYCLES = urhps_pkg::URHPS_RESUME_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire urhps_pkg::urhps_pin_t [NUM_PORTS-1:0] port_pin,
  output logic [NUM_PORTS-1:0] port_reset_drive,
  output logic [NUM_PORTS-1:0] port_resume_drive,
  output logic [NUM_PORTS-1:0] port_power_drive,
  output logic [NUM_PORTS-1:0] port_enable_drive
);
  if (NUM_PORTS < 2 || NUM_PORTS > 3 || RESET_CYCLES < 1 || RESUME_CYCLES < 1) begin : gen_bad_param
    $error("urhps_top: unsupported parameter value");
  end

  // ----------------------------------------
  // axi4-lite write address, write data and write response channels
  // ----------------------------------------
  logic [7:0] awaddr_reg;
  logic aw_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_have_reg;
  logic [31:0] cfg_reg;
  logic wr_fire;
  logic [31:0] wr_bits;
  logic [31:0] wr_be;
  logic wr_hit_port [NUM_PORTS];
  logic wr_mapped;

  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  always_comb begin
    wr_bits = 32'h0000_0000;
    wr_be = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      if (wstrb_reg[b]) begin
        wr_bits[b*8 +: 8] = wdata_reg[b*8 +: 8];
        wr_be[b*8 +: 8] = 8'hff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      w_have_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_reg && !s_axi_bvalid;
    end
  end

  logic port3_on;
  assign port3_on = (NUM_PORTS > 2) && cfg_reg[urhps_pkg::URHPS_CFG_PORT3_EN];
  always_comb begin
    wr_mapped = (awaddr_reg == urhps_pkg::URHPS_CFG_OFFSET);
    for (int p = 0; p < NUM_PORTS; p++) begin
      wr_hit_port[p] = wr_fire && (awaddr_reg == 8'(urhps_pkg::URHPS_PORT1_OFFSET + 8'(4 * p)))
        && (p < 2 || port3_on);
      if (wr_hit_port[p]) begin
        wr_mapped = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= urhps_pkg::URHPS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? urhps_pkg::URHPS_RESP_OKAY : urhps_pkg::URHPS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  logic usb_reset;
  assign usb_reset = cfg_reg[urhps_pkg::URHPS_CFG_USB_RESET];
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_reg <= urhps_pkg::URHPS_CFG_RESET;
    end else if (wr_fire && awaddr_reg == urhps_pkg::URHPS_CFG_OFFSET) begin
      // plain read/write: strobed bytes replace the writable bits, zeros included
      cfg_reg <= (cfg_reg & ~(wr_be & urhps_pkg::URHPS_CFG_WMASK)) | (wr_bits & urhps_pkg::URHPS_CFG_WMASK);
    end
  end

  // ----------------------------------------
  // per-port state
  // ----------------------------------------
  urhps_pkg::urhps_port_t port_reg [NUM_PORTS];
  logic [31:0] port_view [NUM_PORTS];

  for (genvar g = 0; g < NUM_PORTS; g++) begin : gen_port
    logic [2:0] pin_s1_reg;
    logic [2:0] pin_s2_reg;
    logic [2:0] pin_s3_reg;
    logic att_f_reg;
    logic slow_f_reg;
    logic ovl_f_reg;
    logic fixed;
    logic [31:0] rst_cnt_reg;
    logic [31:0] res_cnt_reg;
    logic rst_end;
    logic res_end;
    logic att_now;
    logic [31:0] wb;

    assign fixed = cfg_reg[urhps_pkg::URHPS_CFG_FIXED_LSB + g];
    assign wb = wr_hit_port[g] ? wr_bits : 32'h0000_0000;

    // three-stage pin synchroniser; change accepted when stages two and three agree
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        pin_s1_reg <= 3'h0;
        pin_s2_reg <= 3'h0;
        pin_s3_reg <= 3'h0;
        att_f_reg <= 1'b0;
        slow_f_reg <= 1'b0;
        ovl_f_reg <= 1'b0;
      end else begin
        pin_s1_reg <= port_pin[g];
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        if (pin_s2_reg[2] == pin_s3_reg[2]) att_f_reg <= pin_s3_reg[2];
        if (pin_s2_reg[1] == pin_s3_reg[1]) slow_f_reg <= pin_s3_reg[1];
        if (pin_s2_reg[0] == pin_s3_reg[0]) ovl_f_reg <= pin_s3_reg[0];
      end
    end

    assign att_now = fixed | att_f_reg;
    assign rst_end = port_reg[g].rst && rst_cnt_reg == 32'(RESET_CYCLES - 1);
    assign res_end = (res_cnt_reg != 32'h0) && res_cnt_reg == 32'(RESUME_CYCLES);

    always_ff @(posedge clk) begin
      if (!rst_b || usb_reset || !(g < 2 || port3_on)) begin
        rst_cnt_reg <= 32'h0;
      end else if (port_reg[g].rst) begin
        rst_cnt_reg <= rst_end ? 32'h0 : rst_cnt_reg + 32'h1;
      end else begin
        rst_cnt_reg <= 32'h0;
      end
    end

    // resume counter runs from the write of bit 3 while suspended
    always_ff @(posedge clk) begin
      if (!rst_b || usb_reset || !(g < 2 || port3_on)) begin
        res_cnt_reg <= 32'h0;
      end else if (res_end) begin
        res_cnt_reg <= 32'h0;
      end else if (res_cnt_reg != 32'h0) begin
        res_cnt_reg <= res_cnt_reg + 32'h1;
      end else if (wb[urhps_pkg::URHPS_BIT_OVL] && port_reg[g].susp) begin
        res_cnt_reg <= 32'h1;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_b || usb_reset || !(g < 2 || port3_on)) begin
        port_reg[g] <= '0;
        port_reg[g].att_chg <= fixed;
        port_reg[g].att <= fixed;
      end else begin
        port_reg[g].att <= att_now;
        if (att_now != port_reg[g].att) begin
          port_reg[g].att_chg <= 1'b1;
        end else if (wb[urhps_pkg::URHPS_BIT_ATT_CHG]) begin
          port_reg[g].att_chg <= 1'b0;
        end
        if (!att_now && port_reg[g].en) begin
          port_reg[g].en <= 1'b0;
          port_reg[g].hw_dis <= 1'b1;
        end else begin
          if (wb[urhps_pkg::URHPS_BIT_HW_DIS]) port_reg[g].hw_dis <= 1'b0;
          if (wb[urhps_pkg::URHPS_BIT_ATT]) begin
            port_reg[g].en <= 1'b0;
          end else if (wb[urhps_pkg::URHPS_BIT_EN] || rst_end) begin
            port_reg[g].en <= att_now;
          end
        end
        if (wb[urhps_pkg::URHPS_BIT_SLOW]) begin
          port_reg[g].pwr <= 1'b0;
        end else if (wb[urhps_pkg::URHPS_BIT_PWR]) begin
          port_reg[g].pwr <= 1'b1;
        end
        if (rst_end) begin
          port_reg[g].rst <= 1'b0;
          port_reg[g].rst_done <= 1'b1;
        end else begin
          if (wb[urhps_pkg::URHPS_BIT_RST] && att_now) port_reg[g].rst <= 1'b1;
          if (wb[urhps_pkg::URHPS_BIT_RST_DONE]) port_reg[g].rst_done <= 1'b0;
        end
        if (res_end) begin
          port_reg[g].susp <= 1'b0;
          port_reg[g].res_done <= 1'b1;
        end else begin
          if (wb[urhps_pkg::URHPS_BIT_SUSP] && port_reg[g].en) port_reg[g].susp <= 1'b1;
          if (wb[urhps_pkg::URHPS_BIT_RES_DONE]) port_reg[g].res_done <= 1'b0;
        end
      end
    end

    // read view; unlisted bits stay zero
    always_comb begin
      port_view[g] = 32'h0000_0000;
      port_view[g][urhps_pkg::URHPS_BIT_RST_DONE] = port_reg[g].rst_done;
      port_view[g][urhps_pkg::URHPS_BIT_RES_DONE] = port_reg[g].res_done;
      port_view[g][urhps_pkg::URHPS_BIT_HW_DIS] = port_reg[g].hw_dis;
      port_view[g][urhps_pkg::URHPS_BIT_ATT_CHG] = port_reg[g].att_chg;
      port_view[g][urhps_pkg::URHPS_BIT_SLOW] = port_reg[g].att & slow_f_reg;
      port_view[g][urhps_pkg::URHPS_BIT_PWR] = port_reg[g].pwr
        | cfg_reg[urhps_pkg::URHPS_CFG_ALWAYS_POWERED];
      port_view[g][urhps_pkg::URHPS_BIT_RST] = port_reg[g].rst;
      port_view[g][urhps_pkg::URHPS_BIT_OVL] = ovl_f_reg
        & !cfg_reg[urhps_pkg::URHPS_CFG_GUARD_OFF] & cfg_reg[urhps_pkg::URHPS_CFG_PER_PORT];
      port_view[g][urhps_pkg::URHPS_BIT_SUSP] = port_reg[g].susp;
      port_view[g][urhps_pkg::URHPS_BIT_EN] = port_reg[g].en;
      port_view[g][urhps_pkg::URHPS_BIT_ATT] = port_reg[g].att;
    end

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        port_reset_drive[g] <= 1'b0;
        port_resume_drive[g] <= 1'b0;
        port_power_drive[g] <= 1'b0;
        port_enable_drive[g] <= 1'b0;
      end else begin
        port_reset_drive[g] <= port_reg[g].rst;
        port_resume_drive[g] <= res_cnt_reg != 32'h0;
        port_power_drive[g] <= port_view[g][urhps_pkg::URHPS_BIT_PWR];
        port_enable_drive[g] <= port_reg[g].en;
      end
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b0;
    if (s_axi_araddr == urhps_pkg::URHPS_CFG_OFFSET) begin
      rd_word = cfg_reg;
      rd_ok = 1'b1;
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (s_axi_araddr == 8'(urhps_pkg::URHPS_PORT1_OFFSET + 8'(4 * p)) && (p < 2 || port3_on)) begin
        rd_word = port_view[p];
        rd_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= urhps_pkg::URHPS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? urhps_pkg::URHPS_RESP_OKAY : urhps_pkg::URHPS_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// ==== urhps_pkg.sv ====
// constants and types for the root hub port status block
package urhps_pkg;
  localparam logic [7:0] URHPS_PORT1_OFFSET = 8'h54;
  localparam logic [7:0] URHPS_PORT2_OFFSET = 8'h58;
  localparam logic [7:0] URHPS_PORT3_OFFSET = 8'h5c;
  localparam logic [7:0] URHPS_CFG_OFFSET = 8'h60;
  localparam logic [31:0] URHPS_PORT_RESET = 32'h0000_0000;
  localparam int URHPS_BIT_RST_DONE = 20;
  localparam int URHPS_BIT_RES_DONE = 18;
  localparam int URHPS_BIT_HW_DIS = 17;
  localparam int URHPS_BIT_ATT_CHG = 16;
  localparam int URHPS_BIT_SLOW = 9;
  localparam int URHPS_BIT_PWR = 8;
  localparam int URHPS_BIT_RST = 4;
  localparam int URHPS_BIT_OVL = 3;
  localparam int URHPS_BIT_SUSP = 2;
  localparam int URHPS_BIT_EN = 1;
  localparam int URHPS_BIT_ATT = 0;
  // configuration register fields
  localparam int URHPS_CFG_USB_RESET = 0;
  localparam int URHPS_CFG_ALWAYS_POWERED = 1;
  localparam int URHPS_CFG_GUARD_OFF = 2;
  localparam int URHPS_CFG_PER_PORT = 3;
  localparam int URHPS_CFG_FIXED_LSB = 4;
  localparam int URHPS_CFG_PORT3_EN = 26;
  localparam logic [31:0] URHPS_CFG_WMASK = 32'h0400_007f;
  localparam logic [31:0] URHPS_CFG_RESET = 32'h0000_0001;
  // timing
  localparam int URHPS_CLK_HZ = 10_000_000;
  localparam int URHPS_RESET_TIME_MS = 10;
  localparam int URHPS_RESUME_TIME_MS = 20;
  localparam int URHPS_RESET_CYCLES = URHPS_CLK_HZ / 1000 * URHPS_RESET_TIME_MS;
  localparam int URHPS_RESUME_CYCLES = URHPS_CLK_HZ / 1000 * URHPS_RESUME_TIME_MS;
  localparam logic [1:0] URHPS_RESP_OKAY = 2'b00;
  localparam logic [1:0] URHPS_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic att;
    logic slow;
    logic ovl;
  } urhps_pin_t;

  typedef struct packed {
    logic att;
    logic en;
    logic susp;
    logic pwr;
    logic rst;
    logic rst_done;
    logic res_done;
    logic hw_dis;
    logic att_chg;
  } urhps_port_t;
endpackage

// ==== urhps_chk.sv ====
// concurrent checks on the port status block's ports
`timescale 1ns/10ps
module urhps_chk #(
  parameter int NUM_PORTS = 3,
  parameter int RESET_CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_PORTS-1:0] port_reset_drive,
  input wire logic [NUM_PORTS-1:0] port_enable_drive
);
  // ---------------------------------------------
  // helper state: last read address, reset length
  // ---------------------------------------------
  logic [7:0] ra_reg;
  int rc_reg;
  logic rd_port;
  logic rd_bad;
  always_ff @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra_reg <= s_axi_araddr;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b || !port_reset_drive[0]) begin
      rc_reg <= 0;
    end else begin
      rc_reg <= rc_reg + 1;
    end
  end
  assign rd_port = ra_reg == 8'h54 || ra_reg == 8'h58 || ra_reg == 8'h5c;
  assign rd_bad = !rd_port && ra_reg != 8'h60;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rst_end;
    $past(rst_b) && $fell(port_reset_drive[0]);
  endsequence
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read not answered one cycle after address");
  a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_reserved_zero: assert property (
    s_axi_rvalid && rd_port |-> (s_axi_rdata & 32'hffe0_fce0) == 32'h0)
    else $error("reserved port bits read nonzero");
  a_slow_attached: assert property (
    s_axi_rvalid && rd_port && s_axi_rdata[9] |-> s_axi_rdata[0])
    else $error("slow flag without attached device");
  a_unmapped_read: assert property (s_axi_rvalid && rd_bad |->
    s_axi_rresp == urhps_pkg::URHPS_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_reset_length: assert property (
    s_rst_end |-> rc_reg >= RESET_CYCLES - 1 && rc_reg <= RESET_CYCLES + 1)
    else $error("port reset length wrong");
  a_done_enables: assert property (
    s_rst_end |-> ##[0:2] port_enable_drive[0])
    else $error("port not enabled after reset");
endmodule

// ==== urhps_dev.sv ====
// behavioural usb devices hanging on the root hub ports
`timescale 1ns/10ps
module urhps_dev (
  output urhps_pkg::urhps_pin_t [2:0] port_pin
);
  initial begin
    port_pin = '0;
  end
  // a detached device leaves the speed line floating: show it inverted
  task automatic plug(input int p, input logic att, input logic slow);
    port_pin[p].att <= att;
    port_pin[p].slow <= att ? slow : ~port_pin[p].slow;
  endtask
  task automatic overload(input int p, input logic v);
    port_pin[p].ovl <= v;
  endtask
endmodule

// ==== urhps_tb.sv ====
// self-checking bench for the root hub port status block
`timescale 1ns/10ps
module urhps_tb;
  localparam int NUM_PORTS = 3;
  localparam int RESET_CYCLES = 8;
  localparam int RESUME_CYCLES = 12;
  localparam logic [7:0] P1 = urhps_pkg::URHPS_PORT1_OFFSET;
  localparam logic [7:0] P2 = urhps_pkg::URHPS_PORT2_OFFSET;
  localparam logic [7:0] P3 = urhps_pkg::URHPS_PORT3_OFFSET;
  localparam logic [7:0] CF = urhps_pkg::URHPS_CFG_OFFSET;
  localparam logic [1:0] OK = urhps_pkg::URHPS_RESP_OKAY;
  localparam logic [1:0] ER = urhps_pkg::URHPS_RESP_SLVERR;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NUM_PORTS-1:0] rst_drv, res_drv, pwr_drv, en_drv;
  urhps_pkg::urhps_pin_t [NUM_PORTS-1:0] port_pin;
  int n_errors, compares, cyc;
  logic [1:0] wr_exp;
  urhps_top #(.NUM_PORTS(NUM_PORTS), .RESET_CYCLES(RESET_CYCLES), .RESUME_CYCLES(RESUME_CYCLES)) DUT (
    .clk(clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_pin(port_pin), .port_reset_drive(rst_drv), .port_resume_drive(res_drv),
    .port_power_drive(pwr_drv), .port_enable_drive(en_drv));
  urhps_dev u_dev (.port_pin(port_pin));
  // ---------------------------------------------
  // clock, timeout and checking tasks
  // ---------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task conclude;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge clk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        b = 1'b1;
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, wr_exp});
      end
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
    logic t;
    t = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!t) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        t = 1'b1;
        s_axi_rready <= 1'b0;
        chk({30'h0, s_axi_rresp}, {30'h0, r});
        chk(s_axi_rdata & m, e);
      end
    end
  endtask
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    wr_exp = OK;
    {n_errors, compares, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(CF, ALL, urhps_pkg::URHPS_CFG_RESET, OK);
    rd(P1, ALL, 32'h0, OK);
    rd(8'h70, ALL, 32'h0, ER);
    rd(P3, ALL, 32'h0, ER);
    wr_exp = ER;
    wr(P3, 32'h100);
    wr(8'h70, ALL);
    wr_exp = OK;
    wr(CF, 32'h0000_0021);
    rd(P2, ALL, 32'h1_0001, OK);
    wr(CF, 32'h0400_0020);
    rd(P3, ALL, 32'h0, OK);
    wr(P3, 32'hffe0_fce0);
    rd(P3, ALL, 32'h0, OK);
    $display("test defaults done");
    wr(P1, 32'h100);
    rd(P1, ALL, 32'h100, OK);
    chk({29'h0, pwr_drv}, 32'h1);
    wr(P1, 32'h300);
    rd(P1, ALL, 32'h0, OK);
    wr(P1, 32'h100);
    u_dev.plug(0, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    rd(P1, ALL, 32'h1_0301, OK);
    wr(P1, 32'h1_0000);
    rd(P1, ALL, 32'h301, OK);
    $display("test power attach done");
    wr(P1, 32'h10);
    rd(P1, ALL, 32'h311, OK);
    chk({29'h0, rst_drv}, 32'h1);
    repeat (RESET_CYCLES) @(posedge clk);
    rd(P1, ALL, 32'h10_0303, OK);
    wr(P1, 32'h10_0000);
    rd(P1, ALL, 32'h303, OK);
    wr(P1, 32'h4);
    rd(P1, ALL, 32'h307, OK);
    wr(P1, 32'h8);
    rd(P1, ALL, 32'h307, OK);
    chk({29'h0, res_drv}, 32'h1);
    repeat (RESUME_CYCLES) @(posedge clk);
    rd(P1, ALL, 32'h4_0303, OK);
    wr(P1, 32'h4_0000);
    $display("test reset resume done");
    wr(P1, 32'h1);
    rd(P1, ALL, 32'h301, OK);
    wr(P1, 32'h2);
    rd(P1, ALL, 32'h303, OK);
    chk({29'h0, en_drv}, 32'h1);
    u_dev.plug(0, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    rd(P1, ALL, 32'h3_0100, OK);
    wr(P1, 32'h3_0000);
    rd(P1, ALL, 32'h100, OK);
    s_axi_wstrb <= 4'h1;
    wr(P1, 32'h0000_0200);
    s_axi_wstrb <= 4'hf;
    rd(P1, ALL, 32'h100, OK);
    chk({29'h0, pwr_drv}, 32'h1);
    $display("test disable detach done");
    wr(CF, 32'h0400_002a);
    u_dev.overload(1, 1'b1);
    repeat (8) @(posedge clk);
    rd(P2, 32'h9, 32'h9, OK);
    rd(P3, 32'h100, 32'h100, OK);
    wr(CF, 32'h0400_0001);
    rd(P1, ALL, 32'h0, OK);
    $display("test config done");
    conclude();
  end
endmodule
bind urhps_top urhps_chk #(.NUM_PORTS(NUM_PORTS), .RESET_CYCLES(RESET_CYCLES)) u_chk (
  .clk(clk), .rst_b(rst_b), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_reset_drive(port_reset_drive),
  .port_enable_drive(port_enable_drive));
